//--- hw/qflash_front.sv
// qflash_front: serial command front end of a quad-capable serial flash
// assumes: host drives link_clk and select_n; an array model sits on the core side
`timescale 1ns/100ps
module qflash_front
	import qflash_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	input  wire logic                    link_clk,
	input  wire logic                    select_n,
	input  wire logic [3:0]              quad_data_lines_in,
	output logic      [3:0]              quad_data_lines_out,
	output logic      [3:0]              quad_data_lines_oe,
	input  wire logic                    large_variant,
	input  wire logic [7:0]              array_rdata,
	output logic      [qflash_pkg::ADDR_W-1:0] array_addr,
	output logic                         quad_mode,
	output logic                         write_busy,
	output logic      [7:0]              region_code
);
	////////////////////////////////////////////////////////////////////////
	// link domain: shifting on link_clk, deselect is an asynchronous clear
	typedef enum logic [3:0] {
		ST_CMD  = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_DATA = 4'b0100,
		ST_OUT  = 4'b1000
	} phase_e;

	phase_e            phase_q;
	logic [7:0]        shift_q;
	logic [5:0]        cnt_q;
	logic [7:0]        cmd_q;
	logic [ADDR_W-1:0] addr_q;
	logic              quad_lk_q;
	logic              cmd_t_q;
	logic [7:0]        cmd_evt_q;
	logic [ADDR_W-1:0] cmd_addr_q;
	logic [1:0]        burst_len_q;
	logic              burst_on_q;
	logic              sel_arm_q;
	logic [7:0]        status_lk;
	logic [ADDR_W-1:0] rd_addr_q;
	logic [8:0]        sid_idx_q;

	wire       quad_now   = quad_lk_q;
	wire [5:0] step       = quad_now ? 6'h04 : 6'h01;
	wire [7:0] shift_nx   = quad_now ? {shift_q[3:0], quad_data_lines_in}
	                                 : {shift_q[6:0], quad_data_lines_in[0]};
	wire       byte_done  = (cnt_q + step) == 6'h08;
	wire [5:0] addr_bits  = 6'(ADDR_W);
	wire       addr_done  = (cnt_q + step) == addr_bits;
	wire [ADDR_W-1:0] addr_nx = quad_now ? {addr_q[ADDR_W-5:0], quad_data_lines_in}
	                                     : {addr_q[ADDR_W-2:0], quad_data_lines_in[0]};

	// single mode only honours the read family and enable-quad
	function automatic logic cmd_allowed(input logic [7:0] c, input logic q);
		logic rd;
		rd = (c == CMD_READ) || (c == CMD_FAST_READ) || (c == CMD_ID_READ);
		return q || rd || (c == CMD_EN_QUAD);
	endfunction : cmd_allowed

	function automatic logic cmd_has_addr(input logic [7:0] c);
		return (c == CMD_READ) || (c == CMD_FAST_READ) || (c == CMD_PAGE_PROG) ||
		       (c == CMD_SECTOR_ERS) || (c == CMD_JUMP_BLOCK) ||
		       (c == CMD_JUMP_FAR) || (c == CMD_JUMP_PAGE);
	endfunction : cmd_has_addr

	function automatic logic cmd_is_read(input logic [7:0] c);
		return (c == CMD_READ) || (c == CMD_FAST_READ);
	endfunction : cmd_is_read

	// jump targets: page keeps upper bits, block keeps 64 KB base
	wire [ADDR_W-1:0] jump_page  = {rd_addr_q[ADDR_W-1:8], addr_nx[7:0]};
	wire [ADDR_W-1:0] jump_block = {rd_addr_q[ADDR_W-1:16], addr_nx[15:0]};

	// the link clock may idle low or high; select low frames every edge
	always_ff @(posedge link_clk or posedge select_n) begin
		if (select_n) begin
			phase_q   <= ST_CMD;
			cnt_q     <= '0;
			sel_arm_q <= 1'b1;
		end else begin
			shift_q <= shift_nx;
			cnt_q   <= byte_done && phase_q != ST_ADDR ? 6'h00 :
			           (addr_done && phase_q == ST_ADDR ? 6'h00 : cnt_q + step);
			unique case (phase_q)
				ST_CMD: begin
					if (byte_done && sel_arm_q) begin
						cmd_q     <= shift_nx;
						sel_arm_q <= 1'b0;
						if (!cmd_allowed(shift_nx, quad_now))
							phase_q <= ST_DATA;
						else if (cmd_has_addr(shift_nx))
							phase_q <= ST_ADDR;
						else if (shift_nx == CMD_ID_READ || shift_nx == CMD_RD_STATUS)
							phase_q <= ST_OUT;
						else
							phase_q <= ST_DATA;
					end
				end
				ST_ADDR: begin
					addr_q <= addr_nx;
					if (addr_done) begin
						phase_q <= cmd_is_read(cmd_q) ? ST_OUT : ST_DATA;
						if (cmd_q == CMD_JUMP_PAGE)
							rd_addr_q <= jump_page;
						else if (cmd_q == CMD_JUMP_BLOCK)
							rd_addr_q <= jump_block;
						else
							rd_addr_q <= addr_nx;
					end
				end
				ST_DATA: begin
					if (byte_done && cmd_q == CMD_SET_BURST) begin
						burst_len_q <= shift_nx[1:0];
						burst_on_q  <= shift_nx[4];
					end
				end
				ST_OUT: begin
					if (byte_done)
						rd_addr_q <= wrap_next(rd_addr_q, burst_len_q, burst_on_q);
				end
				default: phase_q <= ST_CMD;
			endcase
		end
	end

	// core reset reaches the link side through two flops
	logic rst_lk_m_q;
	logic rst_lk_q;
	always_ff @(posedge link_clk) begin
		rst_lk_m_q <= reset;
		rst_lk_q   <= rst_lk_m_q;
	end

	wire cmd_take = !select_n && phase_q == ST_CMD && byte_done && sel_arm_q;

	// command event passes to the core as a toggle with held payload
	always_ff @(posedge link_clk) begin
		if (rst_lk_q) begin
			cmd_t_q <= 1'b0;
		end else if (cmd_take && cmd_allowed(shift_nx, quad_now) && !cmd_has_addr(shift_nx)) begin
			cmd_evt_q <= shift_nx;
			cmd_t_q   <= ~cmd_t_q;
		end else if (!select_n && phase_q == ST_ADDR && addr_done) begin
			cmd_evt_q  <= cmd_q;
			cmd_addr_q <= addr_nx;
			cmd_t_q    <= ~cmd_t_q;
		end
	end

	// mode flag set once the enable-quad byte is in; nothing later in that frame counts
	always_ff @(posedge link_clk) begin
		if (rst_lk_q) begin
			quad_lk_q <= 1'b0;
			sid_idx_q <= '0;
		end else if (cmd_take && shift_nx == CMD_EN_QUAD) begin
			quad_lk_q <= 1'b1;
		end
	end

	// output byte chosen at the last input edge, then shifted on falling edges
	logic [7:0] status_sync;
	logic [2:0] out_idx_q;
	logic [1:0] out_byte_q;
	// identity is three bytes; reading on repeats the last one
	wire [7:0] id_byte  = (out_byte_q == 2'h0) ? ID_VALUE[23:16] :
	                      (out_byte_q == 2'h1) ? ID_VALUE[15:8] : ID_VALUE[7:0];
	wire       out_last = quad_now ? out_idx_q[0] : (out_idx_q == 3'h7);
	wire [7:0] out_src  = (cmd_q == CMD_RD_STATUS) ? status_sync :
	                      (cmd_q == CMD_ID_READ)   ? id_byte : array_rdata;
	always_ff @(negedge link_clk or posedge select_n) begin
		if (select_n) begin
			quad_data_lines_oe  <= 4'h0;
			quad_data_lines_out <= 4'h0;
			out_idx_q           <= '0;
			out_byte_q          <= '0;
		end else if (phase_q == ST_OUT) begin
			if (out_last && out_byte_q != 2'h2)
				out_byte_q <= out_byte_q + 2'h1;
			if (quad_now) begin
				quad_data_lines_oe  <= 4'hF;
				quad_data_lines_out <= out_idx_q[0] ? out_src[3:0] : out_src[7:4];
				out_idx_q           <= out_idx_q + 3'd1;
			end else begin
				quad_data_lines_oe  <= 4'h2;
				quad_data_lines_out <= {2'b00, out_src[3'd7 - out_idx_q], 1'b0};
				out_idx_q           <= out_idx_q + 3'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core domain: internal write timer, suspend, status
	logic [1:0]        evt_sync;
	logic              evt_seen_q;
	logic [15:0]       timer_q;
	logic              busy_q;
	logic              susp_erase_q;
	logic              susp_prog_q;
	logic              is_erase_q;

	qflash_sync #(.W(2)) u_evt_sync (
		.clk      (clk_sys),
		.reset    (reset),
		.async_in ({cmd_t_q, quad_lk_q}),
		.sync_out (evt_sync)
	);

	wire evt_pulse = evt_sync[1] ^ evt_seen_q;
	wire [7:0] ecmd = cmd_evt_q;  // stable: held since toggle, two syncs ago
	wire start_wr = evt_pulse && !busy_q && (ecmd == CMD_PAGE_PROG || ecmd == CMD_SECTOR_ERS);
	wire suspend  = evt_pulse && busy_q && ecmd == CMD_SUSPEND;
	wire resume   = evt_pulse && (susp_erase_q || susp_prog_q) && ecmd == CMD_RESUME;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			evt_seen_q   <= 1'b0;
			timer_q      <= '0;
			busy_q       <= 1'b0;
			susp_erase_q <= 1'b0;
			susp_prog_q  <= 1'b0;
			is_erase_q   <= 1'b0;
		end else begin
			evt_seen_q <= evt_sync[1];
			if (start_wr) begin
				busy_q     <= 1'b1;
				timer_q    <= WRITE_CYCLES;
				is_erase_q <= (ecmd == CMD_SECTOR_ERS);
			end else if (suspend) begin
				busy_q       <= 1'b0;
				susp_erase_q <= is_erase_q;
				susp_prog_q  <= !is_erase_q;
			end else if (resume) begin
				busy_q       <= 1'b1;
				susp_erase_q <= 1'b0;
				susp_prog_q  <= 1'b0;
			end else if (busy_q) begin
				timer_q <= timer_q - 16'h0001;
				if (timer_q == 16'h0001)
					busy_q <= 1'b0;
			end
		end
	end

	assign status_lk = {busy_q, 3'b000, susp_prog_q, susp_erase_q, 2'b00};
	qflash_sync #(.W(8)) u_stat_sync (
		.clk      (link_clk),
		.reset    (1'b0),
		.async_in (status_lk),
		.sync_out (status_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// array region classification, core-side registered outputs
	// code: 1 param 8 KB, 2 overlay 32 KB, 3 overlay 64 KB
	wire [ADDR_W-1:0] top_end = large_variant ? 24'h3F_FFFF : 24'h1F_FFFF;
	wire [ADDR_W-1:0] a_now   = cmd_addr_q;
	wire [ADDR_W-1:0] top_par = top_end - ADDR_W'(PARAM_COUNT/2*PARAM_BYTES) + ADDR_W'(1);
	wire [ADDR_W-1:0] top_big = top_par - ADDR_W'(BIG32_BYTES);
	wire in_bot_par = a_now < ADDR_W'(PARAM_COUNT/2*PARAM_BYTES);
	wire in_top_par = a_now >= top_par && a_now <= top_end;
	wire in_bot_big = !in_bot_par && a_now < ADDR_W'(BLOCK_BYTES);
	wire in_top_big = a_now >= top_big && a_now < top_par;
	wire [7:0] region_d = (in_bot_par || in_top_par) ? 8'h01 :
	                      (in_bot_big || in_top_big) ? 8'h02 : 8'h03;
	wire [ADDR_W-1:0] page_base = {a_now[ADDR_W-1:8], 8'h00};
	wire [ADDR_W-1:0] sect_base = {a_now[ADDR_W-1:12], 12'h000};

	// security id: 64 factory bits fixed, 192 user bits reset to all ones and never written
	logic [SECID_USER_BITS-1:0] sid_user_q;
	logic                       sid_lock_q;
	localparam logic [SECID_FACT_BITS-1:0] SID_FACTORY = 64'h0123_4567_89AB_CDEF; // arbitrary
	wire [SECID_BITS-1:0] sid_word = {sid_user_q, SID_FACTORY};

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			array_addr  <= '0;
			quad_mode   <= 1'b0;
			write_busy  <= 1'b0;
			region_code <= 8'h00;
			sid_user_q  <= '1;
			sid_lock_q  <= 1'b0;
		end else begin
			quad_mode  <= evt_sync[0];
			write_busy <= busy_q;
			if (start_wr) begin
				array_addr  <= (ecmd == CMD_SECTOR_ERS) ? sect_base : page_base;
				region_code <= region_d;
			end
			if (evt_pulse && ecmd == CMD_ID_READ && !sid_lock_q)
				sid_lock_q <= sid_word[0];
		end
	end

	wire unused_ok = ^{rd_addr_q, sid_idx_q, BLOCKS_SMALL[0], BLOCKS_LARGE[0],
	                   SECTOR_BYTES[0], BUSY_BIT[0], SUSP_ERASE_BIT[0], SUSP_PROG_BIT[0]};

	////////////////////////////////////////////////////////////////////////
	// checks
	a_busy_hold: assert property (@(posedge clk_sys) disable iff (reset)
		start_wr |=> busy_q [*8]) else $error("busy dropped early");
	a_busy_out: assert property (@(posedge clk_sys) disable iff (reset)
		busy_q |=> write_busy) else $error("busy not shown");
	a_susp_clr: assert property (@(posedge clk_sys) disable iff (reset)
		suspend |=> !busy_q && (susp_erase_q || susp_prog_q)) else $error("suspend lost");
	a_quad_sticky: assert property (@(posedge clk_sys) disable iff (reset)
		quad_mode |=> quad_mode) else $error("quad mode fell");
	a_quad_reset: assert property (@(posedge clk_sys)
		$fell(reset) |-> !quad_mode) else $error("not single after reset");
	a_oe_single: assert property (@(posedge clk_sys) disable iff (reset)
		!quad_mode && quad_data_lines_oe != 4'h0 |-> quad_data_lines_oe == 4'h2)
		else $error("single mode drove data in");
	a_release_sel: assert property (@(posedge clk_sys)
		select_n [*2] |-> quad_data_lines_oe == 4'h0) else $error("outputs not released");
	a_page_align: assert property (@(posedge clk_sys) disable iff (reset)
		start_wr && ecmd == CMD_PAGE_PROG |=> array_addr[7:0] == 8'h00)
		else $error("page not aligned");

	c_write:   cover property (@(posedge clk_sys) start_wr);
	c_suspend: cover property (@(posedge clk_sys) suspend);
	c_quad:    cover property (@(posedge clk_sys) $rose(quad_mode));
	c_status:  cover property (@(posedge link_clk) phase_q == ST_OUT && cmd_q == CMD_RD_STATUS);
endmodule : qflash_front

//--- hw/qflash_pkg.sv
// qflash_pkg: constants for the quad serial flash front end
// assumes: one system clock, one link clock from the host
package qflash_pkg;

	localparam int unsigned ADDR_W          = 24;
	localparam int unsigned PAGE_BYTES      = 256;
	localparam int unsigned SECTOR_BYTES    = 4096;
	localparam int unsigned PARAM_BYTES     = 8192;
	localparam int unsigned PARAM_COUNT     = 8;
	localparam int unsigned BIG32_BYTES     = 32768;
	localparam int unsigned BLOCK_BYTES     = 65536;
	localparam int unsigned BLOCKS_SMALL    = 30;
	localparam int unsigned BLOCKS_LARGE    = 62;
	localparam int unsigned SECID_BITS      = 256;
	localparam int unsigned SECID_FACT_BITS = 64;
	localparam int unsigned SECID_USER_BITS = 192;
	localparam int unsigned BUSY_BIT        = 7;
	localparam int unsigned SUSP_ERASE_BIT  = 2;
	localparam int unsigned SUSP_PROG_BIT   = 3;

	// command codes are this block's own choice
	localparam logic [7:0] CMD_READ        = 8'h03;
	localparam logic [7:0] CMD_FAST_READ   = 8'h0B;
	localparam logic [7:0] CMD_ID_READ     = 8'h9F;
	localparam logic [7:0] CMD_EN_QUAD     = 8'h38;
	localparam logic [7:0] CMD_RD_STATUS   = 8'h05;
	localparam logic [7:0] CMD_PAGE_PROG   = 8'h02;
	localparam logic [7:0] CMD_SECTOR_ERS  = 8'h20;
	localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
	localparam logic [7:0] CMD_RESUME      = 8'h30;
	localparam logic [7:0] CMD_SET_BURST   = 8'hC0;
	localparam logic [7:0] CMD_JUMP_PAGE   = 8'h0C;
	localparam logic [7:0] CMD_JUMP_BLOCK  = 8'h0D;
	localparam logic [7:0] CMD_JUMP_FAR    = 8'h0E;

	// arbitrary identity value, not a real part code
	localparam logic [23:0] ID_VALUE       = 24'h00_A5A5;

	localparam logic [1:0] BURST_8         = 2'h0;
	localparam logic [1:0] BURST_16        = 2'h1;
	localparam logic [1:0] BURST_32        = 2'h2;
	localparam logic [1:0] BURST_64        = 2'h3;

	// length of an internal write, in system clocks (bench-short)
	localparam logic [15:0] WRITE_CYCLES   = 16'h0040;

	function automatic logic [ADDR_W-1:0] wrap_next(
		input logic [ADDR_W-1:0] a,
		input logic [1:0]        len,
		input logic              wrap_on
	);
		logic [ADDR_W-1:0] mask;
		logic [ADDR_W-1:0] inc;
		mask = ADDR_W'(8 << len) - ADDR_W'(1);
		inc  = a + ADDR_W'(1);
		if (wrap_on)
			return (a & ~mask) | (inc & mask);
		return inc;
	endfunction : wrap_next

endpackage : qflash_pkg

//--- hw/qflash_sync.sv
// qflash_sync: two-flop level synchroniser, parameter width
// assumes: input asynchronous to clk
`timescale 1ns/100ps
module qflash_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : qflash_sync

//--- testbench/qflash_host.sv
// qflash_host: behavioural host serial controller driving the flash front end
// assumes: the bench resolves the data lines from both enables
`timescale 1ns/100ps
module qflash_host (
	output logic             link_clk,
	output logic             select_n,
	output logic      [3:0]  host_data,
	output logic      [3:0]  host_oe,
	input  wire logic [3:0]  lines
);
	localparam time HALF = 32ns;
	logic idle_level;

	initial begin
		link_clk   = 1'b0;
		select_n   = 1'b1;
		host_data  = 4'h0;
		host_oe    = 4'h0;
		idle_level = 1'b0;
	end

	// clock pulses with select high, so the link side sees reset
	task automatic idle_clocks(input int n);
		repeat (n) begin
			#(HALF) link_clk = 1'b1;
			#(HALF) link_clk = 1'b0;
		end
	endtask : idle_clocks

	task automatic begin_frame(input logic mode3);
		idle_level = mode3;
		link_clk   = mode3;
		#(HALF) select_n = 1'b0;
		#(HALF);
		if (mode3) begin
			link_clk = 1'b0;
			#(HALF);
		end
	endtask : begin_frame

	// data changes in the low phase, stable across the rising edge
	task automatic send(input int nbits, input logic [31:0] value, input logic quad);
		host_oe = quad ? 4'hF : 4'h1;
		for (int i = nbits - (quad ? 4 : 1); i >= 0; i -= (quad ? 4 : 1)) begin
			if (quad)
				host_data = value[i +: 4];
			else
				host_data[0] = value[i];
			#(HALF) link_clk = 1'b1;
			#(HALF) link_clk = 1'b0;
		end
		host_data = ~host_data;
		host_oe   = 4'h0;
	endtask : send

	// sample at the end of the low phase, after the device shifted
	task automatic recv(input int nbits, input logic quad, output logic [31:0] value);
		value   = '0;
		host_oe = 4'h0;
		for (int i = nbits - (quad ? 4 : 1); i >= 0; i -= (quad ? 4 : 1)) begin
			#(HALF);
			if (quad)
				value[i +: 4] = lines;
			else
				value[i] = lines[1];
			link_clk = 1'b1;
			#(HALF) link_clk = 1'b0;
		end
	endtask : recv

	// select rises before the clock returns to idle: no stray capture edge
	task automatic end_frame();
		#(HALF) select_n = 1'b1;
		host_oe   = 4'h0;
		host_data = ~host_data;
		#(HALF) link_clk = idle_level;
		#(HALF * 2);
	endtask : end_frame

endmodule : qflash_host

//--- testbench/quad_serial_flash_front_end_tb.sv
// quad_serial_flash_front_end_tb: self-checking bench for qflash_front
// assumes: qflash_host stands in for the host controller on the link
`timescale 1ns/100ps
module quad_serial_flash_front_end_tb;
	import qflash_pkg::*;

	logic                    clk_sys;
	logic                    reset;
	logic                    large_variant;
	logic      [7:0]         array_rdata;
	wire logic               link_clk;
	wire logic               select_n;
	wire logic [3:0]         host_data;
	wire logic [3:0]         host_oe;
	wire logic [3:0]         dut_out;
	wire logic [3:0]         dut_oe;
	wire logic [3:0]         lines;
	wire logic [ADDR_W-1:0]  array_addr;
	wire logic               quad_mode;
	wire logic               write_busy;
	wire logic [7:0]         region_code;
	int                      n_fail;
	int                      n_checks;
	int                      cycles;
	int                      busy_len;

	// released lines show the inverse of the host's last value
	assign lines = (dut_oe & dut_out) | (~dut_oe & host_oe & host_data)
		| (~dut_oe & ~host_oe & ~host_data);

	qflash_front i_dut (
		.clk_sys             (clk_sys),
		.reset               (reset),
		.link_clk            (link_clk),
		.select_n            (select_n),
		.quad_data_lines_in  (lines),
		.quad_data_lines_out (dut_out),
		.quad_data_lines_oe  (dut_oe),
		.large_variant       (large_variant),
		.array_rdata         (array_rdata),
		.array_addr          (array_addr),
		.quad_mode           (quad_mode),
		.write_busy          (write_busy),
		.region_code         (region_code)
	);

	qflash_host i_host (
		.link_clk  (link_clk),
		.select_n  (select_n),
		.host_data (host_data),
		.host_oe   (host_oe),
		.lines     (lines)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d, failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check_val

	// the test plan ends well before this limit, so only a hang reaches it
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	always @(posedge clk_sys)
		if (write_busy === 1'b1)
			busy_len++;

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : wait_clk

	////////////////////////////////////////////////////////////
	task automatic test_reset_state();
		check_val("quad_mode", 32'h0, quad_mode);
		check_val("oe", 32'h0, dut_oe);
		check_val("write_busy", 32'h0, write_busy);
	endtask : test_reset_state

	task automatic test_id_single();
		logic [31:0] v;
		i_host.begin_frame(1'b0);
		i_host.send(8, CMD_ID_READ, 1'b0);
		i_host.recv(24, 1'b0, v);
		check_val("oe single", 32'h2, dut_oe);
		check_val("id", ID_VALUE, v);
		i_host.end_frame();
		wait_clk(2);
		check_val("oe idle", 32'h0, dut_oe);
	endtask : test_id_single

	task automatic test_refused_single();
		i_host.begin_frame(1'b0);
		i_host.send(8, CMD_PAGE_PROG, 1'b0);
		i_host.send(24, 32'h0001_2300, 1'b0);
		i_host.end_frame();
		wait_clk(20);
		check_val("busy refused", 32'h0, write_busy);
	endtask : test_refused_single

	task automatic test_enable_quad();
		i_host.begin_frame(1'b0);
		i_host.send(4, CMD_EN_QUAD[7:4], 1'b0);
		i_host.end_frame();
		wait_clk(10);
		check_val("quad partial", 32'h0, quad_mode);
		i_host.begin_frame(1'b1);
		i_host.send(8, CMD_EN_QUAD, 1'b0);
		i_host.end_frame();
		wait_clk(10);
		check_val("quad_mode", 32'h1, quad_mode);
	endtask : test_enable_quad

	task automatic test_quad_program();
		logic [31:0] v;
		busy_len = 0;
		i_host.begin_frame(1'b0);
		i_host.send(8, CMD_PAGE_PROG, 1'b1);
		i_host.send(24, 32'h0012_3400, 1'b1);
		i_host.end_frame();
		for (int i = 0; i < 40 && write_busy !== 1'b1; i++)
			wait_clk(1);
		check_val("busy", 32'h1, write_busy);
		check_val("page base", 32'h0012_3400, array_addr);
		check_val("region block", 32'h3, region_code);
		i_host.begin_frame(1'b0);
		i_host.send(8, CMD_RD_STATUS, 1'b1);
		i_host.recv(8, 1'b1, v);
		check_val("oe quad", 32'hF, dut_oe);
		check_val("status busy", 32'h1, v[BUSY_BIT]);
		i_host.end_frame();
		for (int i = 0; i < 200 && write_busy !== 1'b0; i++)
			wait_clk(1);
		check_val("busy length", WRITE_CYCLES, busy_len);
		i_host.begin_frame(1'b1);
		i_host.send(8, CMD_RD_STATUS, 1'b1);
		i_host.recv(8, 1'b1, v);
		i_host.end_frame();
		check_val("status idle", 32'h0, v[BUSY_BIT]);
	endtask : test_quad_program

	task automatic test_array_read();
		logic [31:0] v;
		array_rdata = 8'hC3;
		i_host.begin_frame(1'b1);
		i_host.send(8, CMD_READ, 1'b1);
		i_host.send(24, 32'h0000_0100, 1'b1);
		i_host.recv(16, 1'b1, v);
		i_host.end_frame();
		check_val("read data", 32'h0000_C3C3, v);
	endtask : test_array_read

	// suspend comes well after the start so the busy hold window has passed
	task automatic test_suspend();
		logic [31:0] v;
		i_host.begin_frame(1'b0);
		i_host.send(8, CMD_SECTOR_ERS, 1'b1);
		i_host.send(24, 32'h0000_1234, 1'b1);
		i_host.end_frame();
		wait_clk(10);
		check_val("erase busy", 32'h1, write_busy);
		check_val("sector base", 32'h0000_1000, array_addr);
		check_val("region param", 32'h1, region_code);
		i_host.begin_frame(1'b0);
		i_host.send(8, CMD_SUSPEND, 1'b1);
		i_host.end_frame();
		wait_clk(5);
		check_val("suspended", 32'h0, write_busy);
		i_host.begin_frame(1'b0);
		i_host.send(8, CMD_RD_STATUS, 1'b1);
		i_host.recv(8, 1'b1, v);
		i_host.end_frame();
		check_val("erase suspended", 32'h1, v[SUSP_ERASE_BIT]);
		check_val("susp not busy", 32'h0, v[BUSY_BIT]);
		i_host.begin_frame(1'b0);
		i_host.send(8, CMD_RESUME, 1'b1);
		i_host.end_frame();
		wait_clk(5);
		check_val("resumed", 32'h1, write_busy);
		for (int i = 0; i < 200 && write_busy !== 1'b0; i++)
			wait_clk(1);
		check_val("erase done", 32'h0, write_busy);
	endtask : test_suspend

	////////////////////////////////////////////////////////////
	initial begin
		n_fail        = 0;
		n_checks      = 0;
		cycles        = 0;
		busy_len      = 0;
		reset         = 1'b1;
		large_variant = 1'b0;
		array_rdata   = 8'h5A;
		// link side needs its own edges to take the reset in
		i_host.idle_clocks(3);
		wait_clk(2);
		reset = 1'b0;
		wait_clk(2);
		test_reset_state();
		test_id_single();
		test_refused_single();
		test_enable_quad();
		large_variant = 1'b1;
		test_quad_program();
		test_array_read();
		test_suspend();
		complete_run();
	end

endmodule : quad_serial_flash_front_end_tb
